// File: dv/ftd_decoder_asserts.sv
// ftd_decoder_asserts.sv: port-level timing and field checks for the decoder.
// Assumes one clock and the decoder's synchronous active-high reset.
`default_nettype none
module ftd_decoder_asserts (
	input wire i_sys_clk,
	input wire i_rst,
	input wire [13:0] i_instr,
	input wire i_instr_valid,
	input wire o_instr_ready,
	input wire [1:0] o_qphase,
	input wire o_cyc_end,
	input wire o_exec,
	input wire o_extra_cycle,
	input wire o_nop_cycle,
	input wire [1:0] o_cycles,
	input wire [1:0] o_class,
	input wire [6:0] o_file_addr,
	input wire o_dest_file,
	input wire [2:0] o_bit_num,
	input wire [7:0] o_lit8,
	input wire o_skip_op,
	input wire o_flow,
	input wire o_file_rd
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	wire take = o_instr_ready && i_instr_valid;
	wire one_end = o_exec && o_cyc_end && !o_skip_op;
	logic [13:0] tw_r;
	always @(posedge i_sys_clk) begin
		if (take) begin
			tw_r <= i_instr;
		end
	end
	property p_fields;
		take |=> o_file_addr == tw_r[6:0] && o_lit8 == tw_r[7:0] &&
		    o_dest_file == tw_r[7] && o_bit_num == tw_r[9:7];
	endproperty
	a_fields: assert property (p_fields)
		else $error("operand fields differ from the taken word");
	property p_class_bit;
		take && i_instr[13:12] == 2'h1 |=> o_class == 2'h1;
	endproperty
	a_class_bit: assert property (p_class_bit)
		else $error("bit-format word not sorted as bit class");
	property p_exec_len;
		$rose(o_exec) |-> o_exec [*4];
	endproperty
	a_exec_len: assert property (p_exec_len)
		else $error("first instruction cycle not four clocks long");
	property p_cyc_period;
		o_cyc_end |=> !o_cyc_end [*3] ##1 o_cyc_end;
	endproperty
	a_cyc_period: assert property (p_cyc_period)
		else $error("cycle end not every four clocks");
	property p_ready_q3;
		o_instr_ready |-> o_cyc_end && o_qphase == 2'h3;
	endproperty
	a_ready_q3: assert property (p_ready_q3)
		else $error("ready outside the last quarter");
	property p_one;
		one_end && o_cycles == 2'h1 |-> o_instr_ready;
	endproperty
	a_one: assert property (p_one)
		else $error("single-cycle instruction not done after one cycle");
	property p_two;
		one_end && o_cycles == 2'h2 |-> !o_instr_ready ##4 o_instr_ready;
	endproperty
	a_two: assert property (p_two)
		else $error("two-cycle instruction not done after two cycles");
	property p_nop;
		o_nop_cycle |-> o_extra_cycle && !o_exec;
	endproperty
	a_nop: assert property (p_nop)
		else $error("no-op outside an extra cycle");
	property p_nop_flow;
		o_extra_cycle && o_flow |-> o_nop_cycle;
	endproperty
	a_nop_flow: assert property (p_nop_flow)
		else $error("extra cycle of a flow change is not a no-op");
	property p_file_rd;
		o_exec && o_qphase == 2'h0 && o_class == 2'h1 |=> o_file_rd;
	endproperty
	a_file_rd: assert property (p_file_rd)
		else $error("bit instruction did not read its file register");
	c_nop: cover property (o_nop_cycle);
	c_ind: cover property (o_extra_cycle && !o_nop_cycle);
	c_take: cover property (take);
endmodule
bind ftd_decoder ftd_decoder_asserts u_chk (.i_sys_clk, .i_rst, .i_instr,
	.i_instr_valid, .o_instr_ready, .o_qphase, .o_cyc_end, .o_exec,
	.o_extra_cycle, .o_nop_cycle, .o_cycles, .o_class, .o_file_addr,
	.o_dest_file, .o_bit_num, .o_lit8, .o_skip_op, .o_file_rd,
	.o_flow);
`default_nettype wire

// File: dv/ftd_decoder_tb.sv
// ftd_decoder_tb.sv: self-checking bench for the instruction decoder.
// Assumes the fetch model and the bound checker are compiled alongside.
`default_nettype none
module ftd_decoder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic skip = 1'b0;
	logic p0 = 1'b0;
	logic p1 = 1'b0;
	logic push = 1'b0;
	logic [13:0] pw = 14'h0000;
	wire [13:0] w_instr;
	wire w_valid;
	wire w_ready;
	wire [2:0] upd_w = {dut.o_upd_carry, dut.o_upd_digit_carry,
		dut.o_upd_zero};
	int err_total = 0;
	int cmp_count = 0;
	logic [13:0] fw [8] = '{14'h2555, 14'h2FFF, 14'h0008, 14'h0009,
		14'h000A, 14'h000B, 14'h34A5, 14'h33FF};
	ftd_fetch_model mem (.i_sys_clk(clk), .i_rst(rst), .i_push(push),
		.i_word(pw), .i_instr_ready(w_ready), .o_instr(w_instr),
		.o_instr_valid(w_valid));
	ftd_decoder dut (.i_sys_clk(clk), .i_rst(rst), .i_instr(w_instr),
		.i_instr_valid(w_valid), .o_instr_ready(w_ready),
		.i_skip_true(skip), .i_ptr0_msb(p0), .i_ptr1_msb(p1),
		.o_qphase(), .o_cyc_end(), .o_exec(), .o_extra_cycle(),
		.o_nop_cycle(), .o_cycles(), .o_class(), .o_known(),
		.o_op_only(), .o_word(), .o_file_addr(), .o_dest_file(),
		.o_bit_num(), .o_lit8(), .o_lit11(), .o_lit7(), .o_lit5(),
		.o_lit9(), .o_ptr_idx(), .o_lit6(), .o_ptr_mode(), .o_flow(),
		.o_skip_op(), .o_call(), .o_return(), .o_indirect(),
		.o_file_rd(), .o_file_wr(), .o_wreg_wr(), .o_upd_carry(),
		.o_upd_digit_carry(), .o_upd_zero());
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [13:0] e,
	    input logic [13:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Runs one word and counts instruction cycles until ready returns.
	task automatic go(input logic [13:0] w, input logic sk,
	    input logic [13:0] ec, input logic en);
		logic [13:0] n;
		logic nop;
		n = 14'h0000;
		nop = 1'b0;
		@(posedge clk);
		skip <= sk;
		pw <= w;
		push <= 1'b1;
		@(posedge clk);
		push <= 1'b0;
		for (int k = 0; k < 20; k++) begin
			@(posedge clk);
			#1;
			if (dut.o_exec === 1'b1 && dut.o_qphase === 2'h0)
				break;
		end
		chk("take", 14'h1, {13'h0, dut.o_exec === 1'b1});
		for (int k = 0; k < 20; k++) begin
			nop = nop | (dut.o_nop_cycle === 1'b1);
			if (dut.o_cyc_end === 1'b1)
				n++;
			if (w_ready === 1'b1)
				break;
			@(posedge clk);
			#1;
		end
		chk("cycles", ec, n);
		chk("nop", {13'h0, en}, {13'h0, nop});
	endtask
	task automatic t_byte();
		go(14'h07FF, 1'b0, 14'h1, 1'b0);
		chk("class", 14'h0, dut.o_class);
		chk("faddr", 14'h7F, dut.o_file_addr);
		chk("dest", 14'h1, dut.o_dest_file);
		chk("word", 14'h07FF, dut.o_word);
		chk("fwr", 14'h1, dut.o_file_wr);
		chk("flags", 14'h7, upd_w);
		go(14'h0700, 1'b0, 14'h1, 1'b0);
		chk("faddr", 14'h00, dut.o_file_addr);
		chk("dest", 14'h0, dut.o_dest_file);
		chk("wwr", 14'h1, dut.o_wreg_wr);
		chk("fwr", 14'h0, dut.o_file_wr);
		go(14'h0103, 1'b0, 14'h1, 1'b0);
		chk("class", 14'h0, dut.o_class);
		go(14'h35A5, 1'b0, 14'h1, 1'b0);
		chk("class", 14'h0, dut.o_class);
		chk("flags", 14'h5, upd_w);
	endtask
	task automatic t_skip();
		go(14'h1E92, 1'b1, 14'h2, 1'b1);
		chk("class", 14'h1, dut.o_class);
		chk("bit", 14'h5, dut.o_bit_num);
		chk("faddr", 14'h12, dut.o_file_addr);
		go(14'h1E92, 1'b0, 14'h1, 1'b0);
		go(14'h1812, 1'b1, 14'h2, 1'b1);
		go(14'h0B81, 1'b1, 14'h2, 1'b1);
	endtask
	task automatic t_flow();
		for (int i = 0; i < 8; i++) begin
			go(fw[i], 1'b0, 14'h2, 1'b1);
			chk("flow", 14'h1, dut.o_flow);
			chk("call", {13'h0, i == 0 || i == 4}, dut.o_call);
			chk("ret", {13'h0, i == 2 || i == 3 || i == 6},
			    dut.o_return);
			chk("oponly", {13'h0, i > 1 && i < 6}, dut.o_op_only);
			if (i == 0)
				chk("lit11", 14'h555, dut.o_lit11);
			if (i == 6)
				chk("lit8", 14'hA5, dut.o_lit8);
			if (i == 7)
				chk("lit9", 14'h1FF, dut.o_lit9);
		end
	endtask
	task automatic t_lit();
		go(14'h30A5, 1'b0, 14'h1, 1'b0);
		chk("lit8", 14'hA5, dut.o_lit8);
		chk("known", 14'h1, dut.o_known);
		go(14'h0004, 1'b0, 14'h1, 1'b0);
		chk("known", 14'h0, dut.o_known);
		go(14'h31FF, 1'b0, 14'h1, 1'b0);
		chk("lit7", 14'h7F, dut.o_lit7);
		go(14'h0035, 1'b0, 14'h1, 1'b0);
		chk("lit5", 14'h15, dut.o_lit5);
		go(14'h316A, 1'b0, 14'h1, 1'b0);
		chk("pidx", 14'h1, dut.o_ptr_idx);
		chk("lit6", 14'h2A, dut.o_lit6);
		go(14'h0016, 1'b0, 14'h1, 1'b0);
		chk("mode", 14'h2, dut.o_ptr_mode);
	endtask
	task automatic t_ind();
		@(posedge clk);
		p0 <= 1'b1;
		go(14'h0780, 1'b0, 14'h2, 1'b0);
		chk("ind", 14'h1, dut.o_indirect);
		go(14'h0781, 1'b0, 14'h1, 1'b0);
		@(posedge clk);
		p0 <= 1'b0;
		p1 <= 1'b1;
		go(14'h0781, 1'b0, 14'h2, 1'b0);
		go(14'h3F45, 1'b0, 14'h2, 1'b0);
		chk("lit6", 14'h05, dut.o_lit6);
		@(posedge clk);
		p1 <= 1'b0;
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_byte();
		t_skip();
		t_flow();
		t_lit();
		t_ind();
		summarize();
	end
	// The whole sequence needs well under a thousand clocks.
	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		summarize();
	end
endmodule
`default_nettype wire

// File: dv/ftd_fetch_model.sv
// ftd_fetch_model.sv: program memory fetch path offering one word at a time.
// Assumes pushes come only while no word is pending.
`default_nettype none
module ftd_fetch_model (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_push,
	input wire logic [13:0] i_word,
	input wire logic i_instr_ready,
	output logic [13:0] o_instr,
	output logic o_instr_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [13:0] word_r;
	// A released bus shows the inverse so stale words never look valid.
	assign o_instr = o_instr_valid ? word_r : ~word_r;
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_instr_valid <= 1'b0;
		end else if (i_push) begin
			word_r <= i_word;
			o_instr_valid <= 1'b1;
		end else if (o_instr_ready_taken()) begin
			o_instr_valid <= 1'b0;
		end
	end
	function automatic logic o_instr_ready_taken();
		return o_instr_valid && i_instr_ready;
	endfunction
endmodule
`default_nettype wire

// File: rtl/ftd_consts.vh
// ftd_consts.vh: field positions, opcode patterns and timing for ftd.
// Assumes it is included by the decoder and its helper modules only.
`ifndef FTD_CONSTS_VH
`define FTD_CONSTS_VH

`define FTD_Q_PER_CYC 4
`define FTD_WORD_W 14

`define FTD_D_BIT 7
`define FTD_F_MSB 6
`define FTD_B_MSB 9
`define FTD_B_LSB 7
`define FTD_K11_MSB 10
`define FTD_K9_MSB 8
`define FTD_K8_MSB 7
`define FTD_K7_MSB 6
`define FTD_K6_MSB 5
`define FTD_K5_MSB 4
`define FTD_N_OFS_BIT 6
`define FTD_N_INC_BIT 2
`define FTD_DIR_OFS_BIT 7
`define FTD_DIR_INC_BIT 3

`define FTD_CLS_BYTE 2'h0
`define FTD_CLS_BIT 2'h1
`define FTD_CLS_LIT 2'h2

`define FTD_ADDR_IND0 7'h00
`define FTD_ADDR_IND1 7'h01

`define FTD_OP_MOVWF 6'h00
`define FTD_OP_CLR 6'h01
`define FTD_OP_SUBWF 6'h02
`define FTD_OP_DECF 6'h03
`define FTD_OP_IORWF 6'h04
`define FTD_OP_ANDWF 6'h05
`define FTD_OP_XORWF 6'h06
`define FTD_OP_ADDWF 6'h07
`define FTD_OP_MOVF 6'h08
`define FTD_OP_COMF 6'h09
`define FTD_OP_INCF 6'h0A
`define FTD_OP_DECSKZ 6'h0B
`define FTD_OP_RRF 6'h0C
`define FTD_OP_RLF 6'h0D
`define FTD_OP_SWAPF 6'h0E
`define FTD_OP_INCSKZ 6'h0F
`define FTD_OP_LSLF 6'h35
`define FTD_OP_LSRF 6'h36
`define FTD_OP_ASRF 6'h37
`define FTD_OP_SUBWFB 6'h3B
`define FTD_OP_ADDWFC 6'h3D

`define FTD_OP_MOVLW 6'h30
`define FTD_OP_RETLIT 6'h34
`define FTD_OP_IORLW 6'h38
`define FTD_OP_ANDLW 6'h39
`define FTD_OP_XORLW 6'h3A
`define FTD_OP_SUBLW 6'h3C
`define FTD_OP_ADDLW 6'h3E
`define FTD_OP_PTROFS 6'h3F

`define FTD_OP_BCLR 4'h4
`define FTD_OP_BSET 4'h5
`define FTD_OP_SKBC 4'h6
`define FTD_OP_SKBS 4'h7

`define FTD_OP_JUMP 3'h5
`define FTD_OP_CALL 3'h4
`define FTD_OP_RBR 5'h19
`define FTD_OP_PAGE 7'h63
`define FTD_OP_ADDPTR 7'h62
`define FTD_OP_BANK 9'h001
`define FTD_OP_PTRINC 10'h001

`define FTD_W_NOP 14'h0000
`define FTD_W_RET 14'h0008
`define FTD_W_IRET 14'h0009
`define FTD_W_WCALL 14'h000A
`define FTD_W_CBR 14'h000B

`endif

// File: rtl/ftd_decoder.v
// ftd_decoder.v: decodes 14-bit words, extracts operand fields and paces
// each instruction in cycles of four oscillator clocks.
// Assumes the fetch path offers a word with valid and the datapath returns
// the skip test result at the end of the first instruction cycle.
`default_nettype none
`include "ftd_consts.vh"

module ftd_decoder (
	input wire i_sys_clk,
	input wire i_rst,
	input wire [13:0] i_instr,
	input wire i_instr_valid,
	output wire o_instr_ready,
	input wire i_skip_true,
	input wire i_ptr0_msb,
	input wire i_ptr1_msb,
	output wire [1:0] o_qphase,
	output wire o_cyc_end,
	output wire o_exec,
	output wire o_extra_cycle,
	output wire o_nop_cycle,
	output wire [1:0] o_cycles,
	output wire [1:0] o_class,
	output wire o_known,
	output wire o_op_only,
	output wire [13:0] o_word,
	output wire [6:0] o_file_addr,
	output wire o_dest_file,
	output wire [2:0] o_bit_num,
	output wire [7:0] o_lit8,
	output wire [10:0] o_lit11,
	output wire [6:0] o_lit7,
	output wire [4:0] o_lit5,
	output wire [8:0] o_lit9,
	output wire o_ptr_idx,
	output wire [5:0] o_lit6,
	output wire [1:0] o_ptr_mode,
	output wire o_flow,
	output wire o_skip_op,
	output wire o_call,
	output wire o_return,
	output wire o_indirect,
	output wire o_file_rd,
	output wire o_file_wr,
	output wire o_wreg_wr,
	output wire o_upd_carry,
	output wire o_upd_digit_carry,
	output wire o_upd_zero
);

	wire [13:0] w = i_instr;
	wire [5:0] op6 = w[13:8];
	wire d = w[`FTD_D_BIT];
	wire [6:0] f = w[`FTD_F_MSB:0];

	wire step;
	wire [1:0] left;
	wire take;
	wire done;
	wire add;

	reg [1:0] cls;
	reg use_f;
	reg wr_f;
	reg wr_w;
	reg fc;
	reg fdc;
	reg fz;
	reg flow;
	reg skip;
	reg call;
	reg ret;
	reg ptr;
	reg ptr_n;
	reg known;
	reg op_only;
	wire ind;
	wire byte_hi;
	wire byte_op;

	reg active_r;
	reg first_r;
	reg [1:0] cycles_r;
	reg flow_r;
	reg skip_r;
	reg taken_r;
	reg [1:0] cls_r;
	reg known_r;
	reg op_only_r;
	reg [13:0] word_r;
	reg call_r;
	reg ret_r;
	reg ind_r;
	reg use_f_r;
	reg wr_f_r;
	reg wr_w_r;
	reg fc_r;
	reg fdc_r;
	reg fz_r;

	ftd_qdiv u_qdiv (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.o_phase(o_qphase),
		.o_cyc_end(step)
	);

	// Shifted and carry-in forms sit in the upper opcode space but still
	// use the byte-oriented layout.
	assign byte_hi = (op6 == `FTD_OP_ADDWFC) || (op6 == `FTD_OP_SUBWFB) ||
		(op6 == `FTD_OP_LSLF) || (op6 == `FTD_OP_LSRF) ||
		(op6 == `FTD_OP_ASRF);
	assign byte_op = ((w[13:12] == 2'h0) &&
		((op6 != `FTD_OP_MOVWF) || d)) || byte_hi;

	always @* begin
		cls = `FTD_CLS_LIT;
		use_f = 1'b0;
		wr_f = 1'b0;
		wr_w = 1'b0;
		fc = 1'b0;
		fdc = 1'b0;
		fz = 1'b0;
		flow = 1'b0;
		skip = 1'b0;
		call = 1'b0;
		ret = 1'b0;
		ptr = 1'b0;
		ptr_n = 1'b0;
		known = 1'b1;
		op_only = 1'b0;
		if (w[13:12] == 2'h1) begin
			cls = `FTD_CLS_BIT;
			use_f = 1'b1;
			case (w[13:10])
				`FTD_OP_BCLR, `FTD_OP_BSET: wr_f = 1'b1;
				default: skip = 1'b1;
			endcase
		end else if (w[13:12] == 2'h2) begin
			flow = 1'b1;
			call = (w[13:11] == `FTD_OP_CALL);
		end else if (byte_op) begin
			cls = `FTD_CLS_BYTE;
			// Clearing the working register touches no file register;
			// its low bits are don't-care.
			use_f = !((op6 == `FTD_OP_CLR) && !d);
			wr_f = d;
			wr_w = !d;
			case (op6)
				`FTD_OP_ADDWF, `FTD_OP_ADDWFC, `FTD_OP_SUBWF,
				`FTD_OP_SUBWFB: begin
					fc = 1'b1;
					fdc = 1'b1;
					fz = 1'b1;
				end
				`FTD_OP_LSLF, `FTD_OP_LSRF, `FTD_OP_ASRF: begin
					fc = 1'b1;
					fz = 1'b1;
				end
				`FTD_OP_RLF, `FTD_OP_RRF: fc = 1'b1;
				`FTD_OP_DECSKZ, `FTD_OP_INCSKZ: skip = 1'b1;
				`FTD_OP_SWAPF, `FTD_OP_MOVWF: fz = 1'b0;
				default: fz = 1'b1;
			endcase
		end else if (w == `FTD_W_NOP) begin
			op_only = 1'b1;
		end else if ((w == `FTD_W_RET) || (w == `FTD_W_IRET)) begin
			op_only = 1'b1;
			flow = 1'b1;
			ret = 1'b1;
		end else if (w == `FTD_W_WCALL) begin
			op_only = 1'b1;
			flow = 1'b1;
			call = 1'b1;
		end else if (w == `FTD_W_CBR) begin
			op_only = 1'b1;
			flow = 1'b1;
		end else if (w[13:5] == `FTD_OP_BANK) begin
			known = 1'b1;
		end else if (w[13:4] == `FTD_OP_PTRINC) begin
			ptr = 1'b1;
			ptr_n = w[`FTD_N_INC_BIT];
			wr_w = !w[`FTD_DIR_INC_BIT];
		end else if (w[13:9] == `FTD_OP_RBR) begin
			flow = 1'b1;
		end else if ((w[13:7] == `FTD_OP_PAGE) ||
			(w[13:7] == `FTD_OP_ADDPTR)) begin
			known = 1'b1;
		end else begin
			case (op6)
				`FTD_OP_ADDLW, `FTD_OP_SUBLW: begin
					wr_w = 1'b1;
					fc = 1'b1;
					fdc = 1'b1;
					fz = 1'b1;
				end
				`FTD_OP_ANDLW, `FTD_OP_IORLW, `FTD_OP_XORLW: begin
					wr_w = 1'b1;
					fz = 1'b1;
				end
				`FTD_OP_MOVLW: wr_w = 1'b1;
				`FTD_OP_RETLIT: begin
					wr_w = 1'b1;
					flow = 1'b1;
					ret = 1'b1;
				end
				`FTD_OP_PTROFS: begin
					ptr = 1'b1;
					ptr_n = w[`FTD_N_OFS_BIT];
					wr_w = !w[`FTD_DIR_OFS_BIT];
				end
				default: known = 1'b0;
			endcase
		end
	end

	// A pointer whose top bit is set addresses program memory, which
	// costs the core one more instruction cycle.
	assign ind = (use_f && (((f == `FTD_ADDR_IND0) && i_ptr0_msb) ||
		((f == `FTD_ADDR_IND1) && i_ptr1_msb))) ||
		(ptr && (ptr_n ? i_ptr1_msb : i_ptr0_msb));

	// The skip result is only known at the end of the first cycle.
	assign add = first_r && skip_r && i_skip_true;
	assign done = (left == 2'h0) && !add;
	assign o_instr_ready = step && done;
	assign take = o_instr_ready && i_instr_valid;

	ftd_stretch u_stretch (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_step(step),
		.i_load(take),
		.i_val({1'b0, flow} + {1'b0, ind}),
		.i_add(add),
		.o_left(left)
	);

	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			active_r <= 1'b0;
			first_r <= 1'b0;
			cycles_r <= 2'h0;
			taken_r <= 1'b0;
		end else if (step) begin
			active_r <= take || !done;
			first_r <= take;
			if (take) begin
				cycles_r <= 2'h1 + {1'b0, flow} + {1'b0, ind};
				taken_r <= flow;
			end else if (add) begin
				cycles_r <= cycles_r + 2'h1;
				taken_r <= 1'b1;
			end
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			word_r <= 14'h0000;
			cls_r <= `FTD_CLS_LIT;
			known_r <= 1'b0;
			op_only_r <= 1'b0;
			flow_r <= 1'b0;
			skip_r <= 1'b0;
			call_r <= 1'b0;
			ret_r <= 1'b0;
			ind_r <= 1'b0;
			use_f_r <= 1'b0;
			wr_f_r <= 1'b0;
			wr_w_r <= 1'b0;
			fc_r <= 1'b0;
			fdc_r <= 1'b0;
			fz_r <= 1'b0;
		end else if (take) begin
			word_r <= w;
			cls_r <= cls;
			known_r <= known;
			op_only_r <= op_only;
			flow_r <= flow;
			skip_r <= skip;
			call_r <= call;
			ret_r <= ret;
			ind_r <= ind;
			use_f_r <= use_f;
			wr_f_r <= wr_f;
			wr_w_r <= wr_w;
			fc_r <= fc;
			fdc_r <= fdc;
			fz_r <= fz;
		end
	end

	assign o_cyc_end = step;
	assign o_exec = first_r;
	assign o_extra_cycle = active_r && !first_r;
	// Every cycle after the first of a flow change does no work.
	assign o_nop_cycle = o_extra_cycle && taken_r;
	assign o_cycles = cycles_r;
	assign o_class = cls_r;
	assign o_known = known_r;
	assign o_op_only = op_only_r;
	assign o_word = word_r;

	// Fields are cut from the held word; the datapath picks by class.
	assign o_file_addr = word_r[`FTD_F_MSB:0];
	assign o_dest_file = word_r[`FTD_D_BIT];
	assign o_bit_num = word_r[`FTD_B_MSB:`FTD_B_LSB];
	assign o_lit8 = word_r[`FTD_K8_MSB:0];
	assign o_lit11 = word_r[`FTD_K11_MSB:0];
	assign o_lit7 = word_r[`FTD_K7_MSB:0];
	assign o_lit5 = word_r[`FTD_K5_MSB:0];
	assign o_lit9 = word_r[`FTD_K9_MSB:0];
	assign o_lit6 = word_r[`FTD_K6_MSB:0];
	assign o_ptr_idx = (word_r[13:12] == 2'h3) ?
		word_r[`FTD_N_OFS_BIT] : word_r[`FTD_N_INC_BIT];
	assign o_ptr_mode = word_r[1:0];

	assign o_flow = flow_r;
	assign o_skip_op = skip_r;
	assign o_call = call_r;
	assign o_return = ret_r;
	assign o_indirect = ind_r;

	// Read early and write in the last quarter so the modify fits between.
	assign o_file_rd = first_r && use_f_r &&
		(o_qphase == 2'h1);
	assign o_file_wr = first_r && wr_f_r && step;
	assign o_wreg_wr = first_r && wr_w_r && step;
	assign o_upd_carry = first_r && fc_r && step;
	assign o_upd_digit_carry = first_r && fdc_r && step;
	assign o_upd_zero = first_r && fz_r && step;

endmodule
`default_nettype wire

// File: rtl/ftd_qdiv.v
// ftd_qdiv.v: splits the oscillator clock into instruction-cycle quarters.
// Assumes one free-running clock and a synchronous active-high reset.
`default_nettype none
`include "ftd_consts.vh"

module ftd_qdiv #(
	parameter DIV = `FTD_Q_PER_CYC
) (
	input wire i_sys_clk,
	input wire i_rst,
	output wire [1:0] o_phase,
	output wire o_cyc_end
);

	reg [1:0] cnt_r;
	wire [31:0] last_full = DIV - 1;

	// The last quarter marks the end of one instruction cycle. The
	// counter is two bits wide, so only dividers up to four fit.
	assign o_cyc_end = (cnt_r == last_full[1:0]);
	assign o_phase = cnt_r;

	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			cnt_r <= 2'h0;
		end else if (o_cyc_end) begin
			cnt_r <= 2'h0;
		end else begin
			cnt_r <= cnt_r + 2'h1;
		end
	end

endmodule
`default_nettype wire

// File: rtl/ftd_stretch.v
// ftd_stretch.v: counts the instruction cycles still owed after the first.
// Assumes load and step come from the decoder on cycle boundaries.
`default_nettype none

module ftd_stretch (
	input wire i_sys_clk,
	input wire i_rst,
	input wire i_step,
	input wire i_load,
	input wire [1:0] i_val,
	input wire i_add,
	output wire [1:0] o_left
);

	reg [1:0] cnt_r;
	reg [1:0] cnt_nxt;
	reg [1:0] sum;

	// A taken skip adds its no-op cycle in the same step that would
	// otherwise retire the first cycle. The cycle that starts at this
	// step is one of those owed, so it is taken off at once.
	always @* begin
		cnt_nxt = cnt_r;
		sum = cnt_r + {1'b0, i_add};
		if (i_load) begin
			cnt_nxt = i_val;
		end else if (i_step) begin
			cnt_nxt = sum - {1'b0, sum != 2'h0};
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			cnt_r <= 2'h0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign o_left = cnt_r;

endmodule
`default_nettype wire
